//--- logic/sms_top.sv
// serial port, master or slave, single buffer or queued, with axi4-lite registers
`timescale 1ns/1ns
`include "sms_params.svh"
module sms_top #(
   parameter int DW       = 16,
   parameter int DEPTH    = `SMS_DEPTH,
   parameter int SCK_HALF = `SMS_SCK_HALF
) (
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   input  wire logic        clk_en,
   input  wire logic        cpu_idle,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        shift_clock_pin_in,
   output logic             shift_clock_pin_out,
   output logic             shift_clock_pin_oe_n,
   input  wire logic        serial_in_pin,
   output logic             serial_out_pin,
   output logic             serial_out_pin_oe_n,
   input  wire logic        select_or_framesync_pin_in,
   output logic             select_or_framesync_pin_out,
   output logic             select_or_framesync_pin_oe_n,
   output logic             port_irq_flag
);
   localparam int CW = $clog2(DEPTH + 1);
   localparam int PW = $clog2(DEPTH);
   localparam int BW = $clog2(DW + 1);
   localparam int HW = $clog2(SCK_HALF + 1);

   ////////////////////////////////////////////////////////////////////////////////
   logic [15:0] con1_ff, con2_ff;
   logic        en_ff, sidl_ff, rov_ff;
   logic [2:0]  irq_condition_select_ff;
   logic [DW-1:0] tx_mem [DEPTH];
   logic [DW-1:0] rx_mem [DEPTH];
   logic [PW-1:0] tx_wp_ff, tx_rp_ff, rx_wp_ff, rx_rp_ff;
   logic [CW-1:0] tx_cnt_ff, rx_cnt_ff, cap;
   sms_pkg::sms_state_type state_ff;
   logic [BW-1:0] bit_cnt_ff;
   logic [HW-1:0] half_cnt_ff;
   logic [DW-1:0] sh_ff;
   logic        phase_ff, fs_ff, rx_bit_ff;
   logic [2:0]  s1_ff, s2_ff, s3_ff, pin_f_ff, pin_prev_ff;
   logic [7:0]  awaddr_ff;
   logic [15:0] wdata_ff;
   logic [1:0]  wstrb_ff;
   logic        aw_ok_ff, w_ok_ff;
   logic        tx_full_prev_ff, rx_full_prev_ff, rx_3q_prev_ff, rx_any_prev_ff;

   wire master = con1_ff[`SMS_B_MASTER_ROLE_SELECT];
   wire cke    = con1_ff[`SMS_B_CKE];
   wire ckp    = con1_ff[`SMS_B_CKP];
   wire select_pin_enable   = con1_ff[`SMS_B_SELECT_PIN_ENABLE];
   wire frmen  = con2_ff[`SMS_B_FRMEN];
   wire fsd    = con2_ff[`SMS_B_FSD];
   wire fpol   = con2_ff[`SMS_B_FPOL];
   wire qen    = con2_ff[`SMS_B_QEN];
   wire run    = en_ff & ~(sidl_ff & cpu_idle);

   ////////////////////////////////////////////////////////////////////////////////
   // bus slave: write address and data taken in either order, one answer each
   wire        do_write = aw_ok_ff & w_ok_ff & ~s_axi_bvalid;
   wire [15:0] wmask    = {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
   wire        wr_stat  = do_write & (awaddr_ff == `SMS_OFF_STAT);
   wire        wr_buf   = do_write & (awaddr_ff == `SMS_OFF_BUF) & (|wstrb_ff);
   wire        wr_con1  = do_write & (awaddr_ff == `SMS_OFF_CON1);
   wire        wr_con2  = do_write & (awaddr_ff == `SMS_OFF_CON2);
   wire        wr_map   = (awaddr_ff == `SMS_OFF_STAT) | (awaddr_ff == `SMS_OFF_BUF)
                        | (awaddr_ff == `SMS_OFF_CON1) | (awaddr_ff == `SMS_OFF_CON2);
   wire        rd_take  = s_axi_arvalid & s_axi_arready;
   wire        rd_buf   = rd_take & (s_axi_araddr == `SMS_OFF_BUF);

   assign s_axi_awready = ~aw_ok_ff & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_ok_ff & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         aw_ok_ff     <= 1'b0;
         w_ok_ff      <= 1'b0;
         awaddr_ff    <= 8'h00;
         wdata_ff     <= `SMS_RST_REG;
         wstrb_ff     <= 2'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `SMS_RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_ok_ff  <= 1'b1;
            awaddr_ff <= {s_axi_awaddr[7:2], 2'h0};
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_ok_ff  <= 1'b1;
            wdata_ff <= s_axi_wdata[15:0];
            wstrb_ff <= s_axi_wstrb[1:0];
         end
         if (do_write) begin
            aw_ok_ff     <= 1'b0;
            w_ok_ff      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? `SMS_RESP_OKAY : `SMS_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // status word; queued-only flags read zero in the single-buffer scheme
   wire [2:0] bec = qen ? (master ? tx_cnt_ff[2:0] : rx_cnt_ff[2:0]) : 3'h0;
   wire shifter_empty_flag  = qen & (state_ff == sms_pkg::ST_IDLE);
   wire rx_queue_empty_flag = qen & (rx_cnt_ff == '0);
   wire tbf    = (tx_cnt_ff == cap);
   wire rbf    = (rx_cnt_ff == cap);
   wire [15:0] stat_word = {en_ff, 1'b0, sidl_ff, 2'h0, bec, shifter_empty_flag, rov_ff,
                            rx_queue_empty_flag, irq_condition_select_ff, tbf, rbf};
   wire [15:0] buf_word  = (rx_cnt_ff != '0) ? 16'(rx_mem[rx_rp_ff]) : 16'h0000;

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `SMS_RESP_OKAY;
      end else if (clk_en) begin
         if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `SMS_RESP_OKAY;
            case (s_axi_araddr)
               `SMS_OFF_STAT: s_axi_rdata <= {16'h0000, stat_word};
               `SMS_OFF_BUF:  s_axi_rdata <= {16'h0000, buf_word};
               `SMS_OFF_CON1: s_axi_rdata <= {16'h0000, con1_ff};
               `SMS_OFF_CON2: s_axi_rdata <= {16'h0000, con2_ff};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `SMS_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // control registers
   wire done_ev;
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         con1_ff  <= `SMS_RST_REG;
         con2_ff  <= `SMS_RST_REG;
         en_ff    <= 1'b0;
         sidl_ff  <= 1'b0;
         irq_condition_select_ff <= 3'h0;
      end else if (clk_en) begin
         if (wr_con1)
            con1_ff <= ((con1_ff & ~wmask) | (wdata_ff & wmask)) & `SMS_CON1_MASK;
         if (wr_con2)
            con2_ff <= ((con2_ff & ~wmask) | (wdata_ff & wmask)) & `SMS_CON2_MASK;
         if (wr_stat & wstrb_ff[1]) begin
            en_ff   <= wdata_ff[`SMS_B_EN];
            sidl_ff <= wdata_ff[`SMS_B_SIDL];
         end
         if (wr_stat & wstrb_ff[0])
            irq_condition_select_ff <= wdata_ff[4:2];
      end
   end

   // overflow is sticky: only a written zero clears it, a new overflow wins
   wire rx_push = done_ev & ~rbf;
   always_ff @(posedge sys_clk) begin
      if (!rstn)
         rov_ff <= 1'b0;
      else if (clk_en) begin
         if (done_ev & rbf)
            rov_ff <= 1'b1;
         else if (wr_stat & wstrb_ff[0] & ~wdata_ff[`SMS_B_ROV])
            rov_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // queues: depth DEPTH when queued, one word otherwise
   assign cap = qen ? CW'(DEPTH) : CW'(1);
   wire ld_ev;
   wire tx_push = wr_buf & ~tbf & en_ff;
   wire tx_pop  = ld_ev & (tx_cnt_ff != '0);
   wire rx_pop  = rd_buf & (rx_cnt_ff != '0);

   always_ff @(posedge sys_clk) begin
      if (!rstn || (clk_en && !en_ff)) begin
         tx_wp_ff  <= '0;
         tx_rp_ff  <= '0;
         tx_cnt_ff <= '0;
      end else if (clk_en) begin
         if (tx_push) begin
            tx_mem[tx_wp_ff] <= wdata_ff[DW-1:0];
            tx_wp_ff         <= (qen && tx_wp_ff != PW'(DEPTH - 1)) ? tx_wp_ff + 1'b1 : '0;
         end
         if (tx_pop)
            tx_rp_ff <= (qen && tx_rp_ff != PW'(DEPTH - 1)) ? tx_rp_ff + 1'b1 : '0;
         tx_cnt_ff <= tx_cnt_ff + CW'(tx_push) - CW'(tx_pop);
      end
   end

   wire [DW-1:0] done_word = {sh_ff[DW-2:0], cke ? rx_bit_ff : pin_f_ff[1]};
   always_ff @(posedge sys_clk) begin
      if (!rstn || (clk_en && !en_ff)) begin
         rx_wp_ff  <= '0;
         rx_rp_ff  <= '0;
         rx_cnt_ff <= '0;
      end else if (clk_en) begin
         if (rx_push) begin
            rx_mem[rx_wp_ff] <= done_word;
            rx_wp_ff         <= (qen && rx_wp_ff != PW'(DEPTH - 1)) ? rx_wp_ff + 1'b1 : '0;
         end
         if (rx_pop)
            rx_rp_ff <= (qen && rx_rp_ff != PW'(DEPTH - 1)) ? rx_rp_ff + 1'b1 : '0;
         rx_cnt_ff <= rx_cnt_ff + CW'(rx_push) - CW'(rx_pop);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: {select, data in, clock}; change counts once stages agree
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         s1_ff       <= 3'h0;
         s2_ff       <= 3'h0;
         s3_ff       <= 3'h0;
         pin_f_ff    <= 3'h0;
         pin_prev_ff <= 3'h0;
      end else if (clk_en) begin
         s1_ff       <= {select_or_framesync_pin_in, serial_in_pin, shift_clock_pin_in};
         s2_ff       <= s1_ff;
         s3_ff       <= s2_ff;
         pin_f_ff    <= (s2_ff & s3_ff) | (pin_f_ff & (s2_ff ^ s3_ff));
         pin_prev_ff <= pin_f_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // shifter: lead edge leaves idle level, trail edge returns to it
   wire shifting  = (state_ff == sms_pkg::ST_SHIFT);
   wire half_done = (half_cnt_ff == HW'(SCK_HALF - 1));
   wire sck_chg   = pin_f_ff[0] ^ pin_prev_ff[0];
   wire sck_act   = pin_f_ff[0] ^ ckp;
   wire fs_in_act = (pin_f_ff[2] == fpol);
   wire sel_act   = ~select_pin_enable | ~pin_f_ff[2];
   wire lead_ev   = run & shifting & (master ? (half_done & ~phase_ff) : (sck_chg & sck_act));
   wire trail_ev  = run & shifting & (master ? (half_done & phase_ff) : (sck_chg & ~sck_act));
   wire samp_ev   = cke ? lead_ev : trail_ev;
   wire shft_ev   = cke ? trail_ev : (lead_ev & (bit_cnt_ff != '0));
   wire start_ok  = master ? ((tx_cnt_ff != '0) & (~frmen | ~fsd | fs_in_act))
                           : (frmen ? fs_in_act : sel_act);
   wire sel_drop  = ~master & ~frmen & select_pin_enable & pin_f_ff[2] & shifting;
   assign ld_ev   = run & (state_ff == sms_pkg::ST_IDLE) & start_ok;
   assign done_ev = trail_ev & (bit_cnt_ff == BW'(DW - 1));

   always_ff @(posedge sys_clk) begin
      if (!rstn || (clk_en && !en_ff)) begin
         state_ff    <= sms_pkg::ST_IDLE;
         bit_cnt_ff  <= '0;
         half_cnt_ff <= '0;
         phase_ff    <= 1'b0;
         fs_ff       <= 1'b0;
         sh_ff       <= '0;
         rx_bit_ff   <= 1'b0;
      end else if (clk_en && run) begin
         if (state_ff != sms_pkg::ST_IDLE)
            half_cnt_ff <= half_done ? '0 : half_cnt_ff + 1'b1;
         if (half_done && state_ff != sms_pkg::ST_IDLE && master)
            phase_ff <= ~phase_ff;
         if (samp_ev)
            rx_bit_ff <= pin_f_ff[1];
         if (shft_ev && !done_ev)
            sh_ff <= {sh_ff[DW-2:0], rx_bit_ff};
         case (state_ff)
            sms_pkg::ST_IDLE: begin
               if (ld_ev) begin
                  sh_ff       <= (tx_cnt_ff != '0) ? tx_mem[tx_rp_ff] : '0;
                  bit_cnt_ff  <= '0;
                  half_cnt_ff <= '0;
                  phase_ff    <= 1'b0;
                  fs_ff       <= master & frmen & ~fsd;
                  state_ff    <= (master & frmen & ~fsd & ~con2_ff[`SMS_B_SPIFE])
                               ? sms_pkg::ST_FRAME : sms_pkg::ST_SHIFT;
               end
            end
            sms_pkg::ST_FRAME: begin
               if (half_done && phase_ff) begin
                  fs_ff    <= 1'b0;
                  state_ff <= sms_pkg::ST_SHIFT;
               end
            end
            sms_pkg::ST_SHIFT: begin
               if (trail_ev) begin
                  fs_ff      <= 1'b0;
                  bit_cnt_ff <= bit_cnt_ff + 1'b1;
               end
               if (done_ev || sel_drop)
                  state_ff <= sms_pkg::ST_IDLE;
            end
            default: state_ff <= sms_pkg::ST_IDLE;
         endcase
      end
   end

   // pins released while the port is off; unused pins stay released
   always_comb begin
      shift_clock_pin_oe_n         = ~(en_ff & master & ~con1_ff[`SMS_B_DIS_SCK]);
      shift_clock_pin_out          = ckp ^ (phase_ff & shifting);
      serial_out_pin_oe_n          = ~(en_ff & ~con1_ff[`SMS_B_DIS_SDO]);
      serial_out_pin               = sh_ff[DW-1];
      select_or_framesync_pin_oe_n = ~(en_ff & frmen & ~fsd);
      select_or_framesync_pin_out  = fs_ff ? fpol : ~fpol;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // interrupt condition: one pulse per selected event
   wire rx_3q = (rx_cnt_ff >= CW'((3 * DEPTH + 3) / 4));
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         port_irq_flag   <= 1'b0;
         tx_full_prev_ff <= 1'b0;
         rx_full_prev_ff <= 1'b0;
         rx_3q_prev_ff   <= 1'b0;
         rx_any_prev_ff  <= 1'b0;
      end else if (clk_en) begin
         tx_full_prev_ff <= tbf;
         rx_full_prev_ff <= rbf;
         rx_3q_prev_ff   <= rx_3q;
         rx_any_prev_ff  <= (rx_cnt_ff != '0);
         case (sms_pkg::sms_irq_sel_type'(irq_condition_select_ff))
            sms_pkg::IRQ_TX_FULL:      port_irq_flag <= tbf & ~tx_full_prev_ff;
            sms_pkg::IRQ_TX_LAST_IN:   port_irq_flag <= tx_pop & (tx_cnt_ff == CW'(1));
            sms_pkg::IRQ_TX_LAST_OUT:  port_irq_flag <= done_ev & (tx_cnt_ff == '0);
            sms_pkg::IRQ_TX_WORD_IN:   port_irq_flag <= tx_pop;
            sms_pkg::IRQ_RX_FULL:      port_irq_flag <= rbf & ~rx_full_prev_ff;
            sms_pkg::IRQ_RX_3Q:        port_irq_flag <= rx_3q & ~rx_3q_prev_ff;
            sms_pkg::IRQ_RX_AVAIL:     port_irq_flag <= (rx_cnt_ff != '0) & ~rx_any_prev_ff;
            sms_pkg::IRQ_RX_LAST_READ: port_irq_flag <= rx_pop & (rx_cnt_ff == CW'(1));
            default:                   port_irq_flag <= 1'b0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk iff clk_en); endclocking
   default disable iff (!rstn);

   property p_master_start;
      (state_ff == sms_pkg::ST_IDLE) && run && master && !frmen && tx_cnt_ff != '0
         |=> shifting && !shift_clock_pin_oe_n == !con1_ff[`SMS_B_DIS_SCK];
   endproperty
   a_master_start: assert property (p_master_start) else $error("master did not start");
   property p_overflow;
      done_ev && rbf |=> rov_ff && $stable(rx_cnt_ff);
   endproperty
   a_overflow: assert property (p_overflow) else $error("overflow not flagged");
   property p_rov_sticky;
      rov_ff && !wr_stat |=> rov_ff;
   endproperty
   a_rov_sticky: assert property (p_rov_sticky) else $error("overflow lost");
   property p_tx_full;
      tx_push && !tx_pop && tx_cnt_ff == cap - CW'(1) |=> tbf;
   endproperty
   a_tx_full: assert property (p_tx_full) else $error("tx full not set");
   property p_rx_full;
      rx_push && !rx_pop && rx_cnt_ff == cap - CW'(1) |=> rbf;
   endproperty
   a_rx_full: assert property (p_rx_full) else $error("rx full not set");
   property p_disabled;
      !en_ff |-> shift_clock_pin_oe_n && serial_out_pin_oe_n && select_or_framesync_pin_oe_n;
   endproperty
   a_disabled: assert property (p_disabled) else $error("pins driven while off");
   property p_idle_stop;
      sidl_ff && cpu_idle && shifting |=> $stable(bit_cnt_ff) && $stable(sh_ff);
   endproperty
   a_idle_stop: assert property (p_idle_stop) else $error("ran while idle");
   property p_legacy_count;
      !qen |-> stat_word[10:7] == 4'h0 && !stat_word[5] && stat_word[14] == 1'b0;
   endproperty
   a_legacy_count: assert property (p_legacy_count) else $error("queued flags in legacy");
   property p_word_len;
      ld_ev && master && !frmen |-> ##[1:300] (state_ff == sms_pkg::ST_IDLE) || !run;
   endproperty
   a_word_len: assert property (p_word_len) else $error("master word too long");

   c_master_word: cover property (done_ev && master);
   c_slave_word:  cover property (done_ev && !master);
   c_overflow:    cover property (done_ev && rbf);
   c_framed:      cover property (state_ff == sms_pkg::ST_FRAME);
endmodule

//--- logic/sms_params.svh
// offsets, field positions, reset values and counts for the serial port block
`ifndef SMS_PARAMS_SVH
`define SMS_PARAMS_SVH
`define SMS_OFF_STAT      8'h00
`define SMS_OFF_BUF       8'h04
`define SMS_OFF_CON1      8'h08
`define SMS_OFF_CON2      8'h0C
`define SMS_RST_REG       16'h0000
`define SMS_CON1_MASK     16'h1BE0
`define SMS_CON2_MASK     16'hE003
`define SMS_STAT_WMASK    16'hA01C
`define SMS_B_EN          15
`define SMS_B_SIDL        13
`define SMS_B_ROV         6
`define SMS_B_DIS_SCK     12
`define SMS_B_DIS_SDO     11
`define SMS_B_SMP         9
`define SMS_B_CKE         8
`define SMS_B_SELECT_PIN_ENABLE        7
`define SMS_B_CKP         6
`define SMS_B_MASTER_ROLE_SELECT       5
`define SMS_B_FRMEN       15
`define SMS_B_FSD         14
`define SMS_B_FPOL        13
`define SMS_B_SPIFE       1
`define SMS_B_QEN         0
`define SMS_DEPTH         8
`define SMS_SCK_HALF      8
`define SMS_RESP_OKAY     2'h0
`define SMS_RESP_SLVERR   2'h2
`endif

//--- logic/sms_pkg.sv
// types shared by the serial port block
package sms_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_SHIFT} sms_state_type;
   typedef enum logic [2:0] {
      IRQ_RX_LAST_READ, IRQ_RX_AVAIL, IRQ_RX_3Q, IRQ_RX_FULL,
      IRQ_TX_WORD_IN, IRQ_TX_LAST_OUT, IRQ_TX_LAST_IN, IRQ_TX_FULL
   } sms_irq_sel_type;
endpackage

//--- dv/sms_link_model.sv
// external serial slave device answering the port in master role
`timescale 1ns/1ns
module sms_link_model (
   input  wire logic        sck,
   input  wire logic        mosi,
   input  wire logic [15:0] reply,
   output logic             miso,
   output logic [15:0]      got,
   output int               words
);
   logic [3:0]  ns;
   logic [3:0]  nb;
   logic [15:0] sh;
   initial begin
      ns = 4'h0;
      nb = 4'h0;
      words = 0;
      got = 16'h0000;
      sh = 16'h0000;
   end
   // msb first, no select line: word framed by counting 16 clocks
   assign miso = reply[4'hf - nb];
   always @(posedge sck) begin
      sh = {sh[14:0], mosi};
      if (ns == 4'hf) begin
         got = sh;
         words++;
      end
      ns = ns + 4'h1;
   end
   // data changes only on the falling edge, so the rising edge sees it settled
   always @(negedge sck) nb <= ns;
endmodule

//--- dv/sms_top_bench.sv
// register-level bench for the serial port in master role
`timescale 1ns/1ns
`include "sms_params.svh"
module sms_top_bench;
   logic        sys_clk = 0, rstn = 0, cpu_idle = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
   logic [7:0]  awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0000_0000, rd;
   logic [1:0]  rs;
   logic [15:0] reply = 16'h0000, got;
   logic        awr, wr, bv, arr, rv, sck_o, sck_oe_n, sdo, miso, irq;
   logic [1:0]  br, rr;
   logic [31:0] rdat;
   int          miscompares = 0, comparisons = 0, cyc = 0, words, irqs = 0, w1;
   always #50 sys_clk = ~sys_clk;
   // half period must exceed the four-edge input path, or samples are one bit late
   sms_top #(.SCK_HALF(`SMS_SCK_HALF)) uut (.sys_clk(sys_clk), .rstn(rstn), .clk_en(1'b1),
      .cpu_idle(cpu_idle), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
      .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
      .s_axi_rvalid(rv), .s_axi_rready(rry), .shift_clock_pin_in(1'b0),
      .shift_clock_pin_out(sck_o), .shift_clock_pin_oe_n(sck_oe_n), .serial_in_pin(miso),
      .serial_out_pin(sdo), .serial_out_pin_oe_n(), .select_or_framesync_pin_in(1'b1),
      .select_or_framesync_pin_out(), .select_or_framesync_pin_oe_n(), .port_irq_flag(irq));
   sms_link_model m (.sck(!sck_oe_n & sck_o), .mosi(sdo), .reply(reply), .miso(miso),
      .got(got), .words(words));
   ////////////////////////////////////////////////////////////////////////////////////
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic pa, pw, ta, tw;
      pa = 1;
      pw = 1;
      @(posedge sys_clk);
      awa <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
      while (pa | pw) begin
         @(negedge sys_clk);
         ta = pa & awr;
         tw = pw & wr;
         @(posedge sys_clk);
         if (ta) begin awv <= 0; pa = 0; end
         if (tw) begin wv <= 0; pw = 0; end
      end
      do @(negedge sys_clk); while (bv !== 1'b1);
      @(posedge sys_clk);
      bry <= 0;
   endtask
   task automatic axr(input logic [7:0] a);
      @(posedge sys_clk);
      ara <= a; arv <= 1; rry <= 1;
      do @(negedge sys_clk); while (arr !== 1'b1);
      @(posedge sys_clk);
      arv <= 0;
      do @(negedge sys_clk); while (rv !== 1'b1);
      rd = rdat;
      rs = rr;
      @(posedge sys_clk);
      rry <= 0;
   endtask
   task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
      comparisons++;
      if (got_v !== exp_v) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got_v, exp_v);
      end
   endtask
   // a read value checked under a mask; the response code is checked unmasked against OKAY
   task automatic rchk(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e);
      axr(a);
      chk(rd & msk, e);
      chk({30'h0, rs}, {30'h0, `SMS_RESP_OKAY});
   endtask
   task automatic xfer(input logic [15:0] d, input logic [15:0] r);
      int w0;
      w0 = words;
      reply = r;
      axw(`SMS_OFF_BUF, {16'h0000, d});
      wait (words == w0 + 1);
      repeat (20) @(posedge sys_clk);
   endtask
   task automatic print_verdict;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // irq is a one-cycle pulse: count every cycle it is seen high
   always @(posedge sys_clk) begin
      if (irq === 1'b1) irqs++;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 30000) begin
         miscompares++;
         print_verdict;
      end
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      rstn <= 1;
      rchk(`SMS_OFF_STAT, 32'hffff_ffff, 32'h0000_0000);
      rchk(`SMS_OFF_CON1, 32'hffff_ffff, 32'h0000_0000);
      axr(8'h10);
      chk({30'h0, rs}, {30'h0, `SMS_RESP_SLVERR});
      axw(`SMS_OFF_CON1, 32'h0000_0120);
      axw(`SMS_OFF_STAT, 32'h0000_8000);
      rchk(`SMS_OFF_STAT, 32'hffff_ffff, 32'h0000_8000);
      xfer(16'ha5c3, 16'h3c5a);
      chk({16'h0, got}, 32'h0000_a5c3);
      rchk(`SMS_OFF_STAT, 32'h0000_0041, 32'h0000_0001);
      rchk(`SMS_OFF_BUF, 32'h0000_ffff, 32'h0000_3c5a);
      rchk(`SMS_OFF_STAT, 32'h0000_0001, 32'h0000_0000);
      xfer(16'h1111, 16'h0f0f);
      xfer(16'h2222, 16'hf0f0);
      rchk(`SMS_OFF_STAT, 32'h0000_0041, 32'h0000_0041);
      rchk(`SMS_OFF_BUF, 32'h0000_ffff, 32'h0000_0f0f);
      axw(`SMS_OFF_STAT, 32'h0000_8000);
      rchk(`SMS_OFF_STAT, 32'hffff_ffff, 32'h0000_8000);
      chk(irqs, 2);
      axw(`SMS_OFF_STAT, 32'h0000_a000);
      w1 = words;
      axw(`SMS_OFF_BUF, 32'h0000_9696);
      repeat (40) @(posedge sys_clk);
      cpu_idle <= 1;
      repeat (400) @(posedge sys_clk);
      chk(words, w1);
      cpu_idle <= 0;
      wait (words == w1 + 1);
      repeat (20) @(posedge sys_clk);
      chk({16'h0, got}, 32'h0000_9696);
      axw(`SMS_OFF_STAT, 32'h0000_0000);
      axw(`SMS_OFF_CON2, 32'h0000_0001);
      axw(`SMS_OFF_STAT, 32'h0000_8004);
      rchk(`SMS_OFF_STAT, 32'h0000_00a1, 32'h0000_00a0);
      for (int i = 0; i < 3; i++) xfer(16'h1234 + 16'(i), 16'h5a50 + 16'(i));
      rchk(`SMS_OFF_STAT, 32'h0000_00a0, 32'h0000_0080);
      for (int i = 0; i < 3; i++) rchk(`SMS_OFF_BUF, 32'h0000_ffff, 32'h5a50 + i);
      chk(irqs, 3);
      rchk(`SMS_OFF_STAT, 32'h0000_0020, 32'h0000_0020);
      print_verdict;
   end
endmodule
